// ---- logic/coll_regs.svh ----
// Register offsets, field positions, reset values and event bits of the collision capture block.
//
// Contract
// - Keep-bits 0: clear received bits after collision.
// - Invalid flag when no collision or out of range.
// - Five-bit position of first collided data bit.
// - Position one is first bit, zero is 32nd.
// - Reset value 101XXXXXb for collision register.
// - Register at 0Eh; bit7 rw, bit6 zero, rest ro.
`ifndef COLL_REGS_SVH
`define COLL_REGS_SVH

`define ADDR_W 6
`define DATA_W 8
`define COLL_STATUS_ADDR 6'h0E
`define IRQ_STATUS_ADDR 6'h30
`define IRQ_MASK_ADDR 6'h31
`define KEEP_BIT 7
`define INVALID_BIT 5
`define POS_HI 4
`define POS_LO 0
`define POS_W 5
`define KEEP_RESET 1'h1
`define INVALID_RESET 1'h1
`define POS_RESET 5'h00
`define MAX_DATA_BITS 6'h20
`define CNT_SAT 6'h3F
`define EV_W 2
`define EV_COLL 0
`define EV_FRAME 1
`define IRQ_RESET 2'h0

`endif

// ---- logic/coll_pkg.sv ----
// Types shared by the collision capture modules.
package coll_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [4:0] coll_pos_t;
    typedef enum logic [1:0] {rx_idle, rx_frame, rx_after_coll} rx_state_t;
endpackage

// ---- logic/rx_bit_if.sv ----
// Bundle of received data-bit signals passed from the top to the capture core.
interface rx_bit_if;
    logic frame_start;
    logic bit_valid;
    logic bit_data;
    logic bit_coll;
    logic frame_end;
    modport src (output frame_start, bit_valid, bit_data, bit_coll, frame_end);
    modport dst (input frame_start, bit_valid, bit_data, bit_coll, frame_end);
endinterface

// ---- logic/coll_capture.sv ----
// Capture core: tracks data bits of a frame and latches the first collision.
`include "coll_regs.svh"
module coll_capture (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Received bit stream
    rx_bit_if.dst rx,
    // Control and result
    input wire logic keep_bits_after_collision,
    output coll_pkg::coll_pos_t first_collision_position,
    output logic collision_position_invalid,
    output logic coll_event,
    output logic out_valid,
    output logic out_data
);
    import coll_pkg::*;

    rx_state_t state_reg;
    logic [5:0] bit_cnt_reg;
    logic [5:0] bit_cnt_next;
    logic found_reg;

    // Running count of data bits; parity and framing never reach this stream.
    assign bit_cnt_next = bit_cnt_reg + 6'h01;

    // Frame tracking; after a collision the state remembers that bits must be cleared.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= rx_idle;
        end else if (rx.frame_start) begin
            state_reg <= rx_frame;
        end else if (rx.frame_end) begin
            state_reg <= rx_idle;
        end else if (rx.bit_valid && rx.bit_coll && state_reg == rx_frame) begin
            state_reg <= rx_after_coll;
        end
    end

    // Bit counter, restarted with each frame.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= 6'h00;
        end else if (rx.frame_start) begin
            bit_cnt_reg <= 6'h00;
        end else if (rx.bit_valid && bit_cnt_reg != `CNT_SAT) begin
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // Position capture; the low five bits of a 1-based count give 32 as zero.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_collision_position <= `POS_RESET;
            collision_position_invalid <= `INVALID_RESET;
            found_reg <= 1'h0;
        end else if (rx.frame_start) begin
            collision_position_invalid <= 1'h1;
            found_reg <= 1'h0;
        end else if (rx.bit_valid && rx.bit_coll && !found_reg) begin
            found_reg <= 1'h1;
            first_collision_position <= bit_cnt_next[`POS_W-1:0];
            // The count before the increment is compared, so a saturated count never wraps back.
            collision_position_invalid <= (bit_cnt_reg >= `MAX_DATA_BITS);
        end
    end

    // Stored bit stream; the colliding bit and all later ones read zero when clearing.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'h0;
            out_data <= 1'h0;
            coll_event <= 1'h0;
        end else begin
            out_valid <= rx.bit_valid;
            coll_event <= rx.bit_valid && rx.bit_coll && !found_reg && !rx.frame_start;
            if (!keep_bits_after_collision
                && (state_reg == rx_after_coll || rx.bit_coll)) begin
                out_data <= 1'h0;
            end else begin
                out_data <= rx.bit_data;
            end
        end
    end
endmodule

// ---- logic/coll_status_top.sv ----
// Top of the collision capture block: pins, register port, interrupt and core.
`include "coll_regs.svh"
module coll_status_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire coll_pkg::reg_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output coll_pkg::reg_byte_t reg_rdata,
    // Receiver bit stream, same clock domain
    input wire logic rx_frame_start,
    input wire logic rx_bit_valid,
    input wire logic rx_bit_data,
    input wire logic rx_bit_coll,
    input wire logic rx_frame_end,
    // Stored bit stream toward the buffer
    output logic store_valid,
    output logic store_data,
    // Interrupt
    output logic irq
);
    import coll_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops.
    logic rst_s1_reg;
    logic rst_n;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_reg <= 1'h0;
            rst_n <= 1'h0;
        end else begin
            rst_s1_reg <= 1'h1;
            rst_n <= rst_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Capture core.
    rx_bit_if rx ();
    assign rx.frame_start = rx_frame_start;
    assign rx.bit_valid = rx_bit_valid;
    assign rx.bit_data = rx_bit_data;
    assign rx.bit_coll = rx_bit_coll;
    assign rx.frame_end = rx_frame_end;

    logic keep_reg;
    coll_pos_t pos;
    logic invalid;
    logic coll_event;

    coll_capture u_capture (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .rx(rx),
        .keep_bits_after_collision(keep_reg),
        .first_collision_position(pos),
        .collision_position_invalid(invalid),
        .coll_event(coll_event),
        .out_valid(store_valid),
        .out_data(store_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Control bit; software should only clear it for 106 kbit anticollision.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            keep_reg <= `KEEP_RESET;
        end else if (reg_wr && reg_addr == `COLL_STATUS_ADDR) begin
            keep_reg <= reg_wdata[`KEEP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky events; a new event in the clearing cycle wins over the clear.
    logic [`EV_W-1:0] irq_status_reg;
    logic [`EV_W-1:0] irq_mask_reg;
    logic [`EV_W-1:0] ev_set;
    assign ev_set = {rx_frame_end, coll_event};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_reg <= `IRQ_RESET;
        end else if (reg_wr && reg_addr == `IRQ_STATUS_ADDR) begin
            irq_status_reg <= (irq_status_reg & ~reg_wdata[`EV_W-1:0]) | ev_set;
        end else begin
            irq_status_reg <= irq_status_reg | ev_set;
        end
    end

    // Mask register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_reg <= `IRQ_RESET;
        end else if (reg_wr && reg_addr == `IRQ_MASK_ADDR) begin
            irq_mask_reg <= reg_wdata[`EV_W-1:0];
        end
    end

    // Interrupt level, registered so the output comes from a flip-flop.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'h0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path; data stand one cycle after the strobe, unmapped reads return zero.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `COLL_STATUS_ADDR: reg_rdata <= {keep_reg, 1'h0, invalid, pos};
                `IRQ_STATUS_ADDR: reg_rdata <= {6'h00, irq_status_reg};
                `IRQ_MASK_ADDR: reg_rdata <= {6'h00, irq_mask_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// ---- test/rx_frame_src.sv ----
// Far-side model: a card that answers with frames of data bits, some of them collided.
module rx_frame_src (
    // Clock
    input wire logic core_clk,
    // Bit stream toward the receiver
    output logic frame_start,
    output logic bit_valid,
    output logic bit_data,
    output logic bit_coll,
    output logic frame_end
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {frame_start, bit_valid, bit_data, bit_coll, frame_end} = 5'h00;
    // Every bit is a one, so a cleared bit shows as a zero; coll_at of 0 means none.
    task automatic send(input int n, input int coll_at);
        @(posedge core_clk) frame_start <= 1'b1;
        for (int i = 1; i <= n; i++) begin
            @(posedge core_clk);
            frame_start <= 1'b0;
            {bit_valid, bit_data} <= 2'h3;
            bit_coll <= (coll_at != 0) && (i == coll_at || i == coll_at + 1);
        end
        // The data line shows the inverse once released, so a stale one never passes.
        @(posedge core_clk);
        {bit_valid, bit_data, bit_coll, frame_end} <= 4'h1;
        @(posedge core_clk) frame_end <= 1'b0;
    endtask
endmodule

// ---- test/coll_status_checker.sv ----
// Port-level concurrent checks of the collision capture top.
`include "coll_regs.svh"
module coll_status_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire coll_pkg::reg_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire coll_pkg::reg_byte_t reg_rdata,
    // Stream and interrupt
    input wire logic rx_frame_start,
    input wire logic rx_bit_valid,
    input wire logic rx_frame_end,
    input wire logic store_valid,
    input wire logic irq
);
    import coll_pkg::*;
    logic quiet;
    logic rd_coll;
    // Quiet cycles start no new event; a coll_event from the cycle before can still set a status bit.
    assign quiet = !rx_bit_valid && !rx_frame_end;
    assign rd_coll = reg_rd && reg_addr == `COLL_STATUS_ADDR;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    store_lag_a: assert property (store_valid == $past(rx_bit_valid))
        else $error("store strobe lag wrong");
    rsv_zero_a: assert property (rd_coll |=> !reg_rdata[6])
        else $error("reserved bit set");
    unmapped_rd_a: assert property (reg_rd && !(reg_addr inside {`COLL_STATUS_ADDR,
        `IRQ_STATUS_ADDR, `IRQ_MASK_ADDR}) |=> reg_rdata == 8'h00) else $error("unmapped read");
    rearm_a: assert property (rx_frame_start ##1 rd_coll |=> reg_rdata[`INVALID_BIT])
        else $error("capture not re-armed");
    keep_rw_a: assert property (reg_wr && reg_addr == `COLL_STATUS_ADDR ##1 rd_coll
        |=> reg_rdata[`KEEP_BIT] == $past(reg_wdata[`KEEP_BIT], 2)) else $error("keep bit lost");
    mask_off_a: assert property (reg_wr && reg_addr == `IRQ_MASK_ADDR && reg_wdata == 8'h00
        ##1 !reg_wr |=> !irq) else $error("irq with mask off");
    clear_off_a: assert property (quiet ##1 quiet && reg_wr && reg_addr == `IRQ_STATUS_ADDR
        && reg_wdata[1:0] == 2'h3 ##1 quiet && !reg_wr |=> !irq) else $error("irq after clear");
    cover property ($rose(irq));
    cover property (rx_frame_start ##1 rd_coll);
    cover property (reg_wr ##1 reg_rd);
endmodule
bind coll_status_top coll_status_checker chk (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_frame_start(rx_frame_start), .rx_bit_valid(rx_bit_valid),
    .rx_frame_end(rx_frame_end), .store_valid(store_valid), .irq(irq));

// ---- test/rf_bit_collision_capture_bench.sv ----
// Self-checking bench of the collision capture top.
`include "coll_regs.svh"
module rf_bit_collision_capture_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import coll_pkg::*;
    localparam int N = 34;
    localparam int AT [5] = '{1, 8, 32, 33, 0};
    localparam bit KP [5] = '{1, 0, 1, 1, 1};
    localparam reg_byte_t EXP [5] = '{8'h81, 8'h08, 8'h80, 8'hA1, 8'hA1};
    logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [`ADDR_W-1:0] reg_addr = '0;
    reg_byte_t reg_wdata = 8'h00, reg_rdata;
    logic fs, bv, bd, bc, fe, store_valid, store_data, irq;
    int err_total = 0, comparisons = 0, ones = 0;
    coll_status_top dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_frame_start(fs), .rx_bit_valid(bv), .rx_bit_data(bd), .rx_bit_coll(bc),
        .rx_frame_end(fe), .store_valid(store_valid), .store_data(store_data), .irq(irq));
    rx_frame_src src (.core_clk(core_clk), .frame_start(fs), .bit_valid(bv), .bit_data(bd),
        .bit_coll(bc), .frame_end(fe));
    initial forever #25 core_clk = ~core_clk;
    // Counts the ones that reach the store side, so cleared bits show as a shortfall.
    always @(posedge core_clk) if (store_valid === 1'b1 && store_data === 1'b1) ones <= ones + 1;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [`ADDR_W-1:0] a, input reg_byte_t d);
        @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk) reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are looked at there.
    task automatic rd(input logic [`ADDR_W-1:0] a, input reg_byte_t exp);
        @(posedge core_clk) {reg_rd, reg_wr, reg_addr} <= {2'h2, a};
        @(posedge core_clk) reg_rd <= 1'b0;
        #1 check("read data", reg_rdata, exp);
    endtask
    task automatic final_report;
        if (err_total == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        final_report;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(`COLL_STATUS_ADDR, 8'hA0);
        rd(`IRQ_MASK_ADDR, 8'h00);
        rd(6'h3F, 8'h00);
        // Write straight into a read; bits 6 to 0 must not take the written ones.
        @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, `COLL_STATUS_ADDR, 8'h7F};
        rd(`COLL_STATUS_ADDR, 8'h20);
        for (int r = 0; r < 5; r++) begin
            wr(`COLL_STATUS_ADDR, {KP[r], 7'h00});
            ones = 0;
            src.send(N, AT[r]);
            repeat (2) @(posedge core_clk);
            rd(`COLL_STATUS_ADDR, EXP[r]);
            check("stored ones", ones, KP[r] ? N : AT[r] - 1);
        end
        // A read in mid-frame sees the capture re-armed and the old position kept.
        fork
            src.send(N, 0);
            begin
                @(posedge core_clk);
                rd(`COLL_STATUS_ADDR, 8'hA1);
            end
        join
        src.send(N, 3);
        repeat (2) @(posedge core_clk);
        #1 check("masked irq", irq, 1'b0);
        rd(`IRQ_STATUS_ADDR, 8'h03);
        wr(`IRQ_MASK_ADDR, 8'h01);
        repeat (2) @(posedge core_clk);
        #1 check("irq", irq, 1'b1);
        wr(`IRQ_STATUS_ADDR, 8'h01);
        repeat (2) @(posedge core_clk);
        #1 check("cleared irq", irq, 1'b0);
        rd(`IRQ_STATUS_ADDR, 8'h02);
        wr(`IRQ_MASK_ADDR, 8'h00);
        rd(`COLL_STATUS_ADDR, 8'h83);
        // A collision beyond the saturated bit counter must still read as out of range.
        src.send(70, 64);
        rd(`COLL_STATUS_ADDR, 8'hA0);
        wr(`IRQ_MASK_ADDR, 8'h03);
        @(posedge core_clk);
        #1 check("irq before reset", irq, 1'b1);
        // Mid-run reset: outputs drop at once and the registers return to their reset image.
        @(posedge core_clk) rstn <= 1'b0;
        #1 check("irq in reset", irq, 1'b0);
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(`COLL_STATUS_ADDR, 8'hA0);
        rd(`IRQ_STATUS_ADDR, 8'h00);
        rd(`IRQ_MASK_ADDR, 8'h00);
        // Clearing both events in a quiet cycle must drop the interrupt.
        wr(`IRQ_MASK_ADDR, 8'h03);
        src.send(N, 5);
        #1 check("irq after frame", irq, 1'b1);
        wr(`IRQ_STATUS_ADDR, 8'h03);
        @(posedge core_clk);
        #1 check("irq after clear", irq, 1'b0);
        rd(`IRQ_STATUS_ADDR, 8'h00);
        rd(`COLL_STATUS_ADDR, 8'h85);
        final_report;
    end
endmodule
